// ==== logic/frame_capture.sv ====
`timescale 1ns/100ps
`default_nettype none

// -----------------------------------------------------------
// Frame capture register
// -----------------------------------------------------------
module frame_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Frame in
  input wire logic in_valid,
  input wire servo_cmd_pkg::can_frame_t in_frame,
  // Frame out
  output logic out_valid,
  output servo_cmd_pkg::can_frame_t out_frame
);

  servo_cmd_pkg::can_frame_t frame_d, frame_q;
  logic valid_d, valid_q;

  always_comb begin
    valid_d = in_valid;
    frame_d = frame_q;
    if (in_valid) begin
      frame_d = in_frame;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
      frame_q <= '0;
    end else begin
      valid_q <= valid_d;
      frame_q <= frame_d;
    end
  end

  assign out_valid = valid_q;
  assign out_frame = frame_q;

endmodule

`default_nettype wire

// ==== logic/servo_can_command_decoder.sv ====
// What this block does
// - Only extended data frames carry commands
// - Mode in id 28..8, node in 7..0
// - Mode codes zero to six decoded
// - Duty: signed 32-bit big-endian, times 100000
// - Duty mode drives square-wave duty setpoint
// - Current: signed 32-bit big-endian milliamps
// - Current mode regulates quadrature current setpoint
// - Brake: signed 32-bit big-endian, 0..60000; the word is stored without clamping
// - Brake mode applies holding brake current
// - Speed: signed 32-bit big-endian ERPM
// - Speed mode runs at commanded speed
// - Position: signed 32-bit big-endian value
// - Position mode moves at maximum speed
// - Origin byte 0..2; 0 temporary, 1 permanent
// - Pos-speed: 4+2+2 bytes, big-endian
// - Pos-speed position signed 32-bit
// - Pos-speed speed signed 16-bit, 10 ERPM
// - Pos-speed accel 0..32767, 10 ERPM/s2
// - Pos-speed move limited by speed, accel
`timescale 1ns/100ps
`default_nettype none
`include "servo_cmd_regs.svh"

module servo_can_command_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic [7:0] node_id,
  // Frames from the CAN controller
  input wire logic rx_valid,
  input wire servo_cmd_pkg::can_frame_t rx_frame,
  // Decoded setpoints to the motor control loops
  output servo_cmd_pkg::servo_setpoint_t setpoint,
  output logic setpoint_valid,
  output logic cmd_strobe,
  // Origin requests
  output logic origin_temporary,
  output logic origin_permanent,
  output logic origin_other,
  // Discard indication
  output logic frame_dropped
);

  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  function automatic logic [31:0] be_word(input logic [63:0] d,
                                          input int idx);
    logic [31:0] w;
    w = {d[63-8*idx -: 8], d[55-8*idx -: 8],
         d[47-8*idx -: 8], d[39-8*idx -: 8]};
    return w;
  endfunction

  function automatic logic [15:0] be_half(input logic [63:0] d,
                                          input int idx);
    logic [15:0] h;
    h = {d[63-8*idx -: 8], d[55-8*idx -: 8]};
    return h;
  endfunction

  // Payload length a mode needs
  function automatic logic [3:0] need_dlc(input logic [20:0] code);
    logic [3:0] n;
    n = `LEN_WORD;
    if (code == `MODE_SET_ORIGIN) begin
      n = `LEN_ORIGIN;
    end else if (code == `MODE_POSITION_SPEED) begin
      n = `LEN_POS_SPD;
    end
    return n;
  endfunction

  // Origin instruction test
  function automatic logic origin_is(input logic [7:0] b,
                                     input logic [7:0] kind);
    logic hit;
    hit = b == kind;
    return hit;
  endfunction

  // Mode code to running mode
  function automatic servo_cmd_pkg::servo_mode_t to_mode(
      input logic [2:0] code);
    servo_cmd_pkg::servo_mode_t m;
    m = servo_cmd_pkg::cmd_duty_cycle;
    unique case (code)
      3'h0: m = servo_cmd_pkg::cmd_duty_cycle;
      3'h1: m = servo_cmd_pkg::cmd_current_loop;
      3'h2: m = servo_cmd_pkg::cmd_brake_current;
      3'h3: m = servo_cmd_pkg::cmd_speed_loop;
      3'h4: m = servo_cmd_pkg::cmd_position_loop;
      3'h5: m = servo_cmd_pkg::cmd_set_origin;
      3'h6: m = servo_cmd_pkg::cmd_position_speed_loop;
      default: m = servo_cmd_pkg::cmd_duty_cycle;
    endcase
    return m;
  endfunction

  // ---------------------------------------------------------
  // Frame capture
  // ---------------------------------------------------------
  logic cap_valid;
  servo_cmd_pkg::can_frame_t cap_frame;

  frame_capture u_capture (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(rx_valid),
    .in_frame(rx_frame),
    .out_valid(cap_valid),
    .out_frame(cap_frame)
  );

  // ---------------------------------------------------------
  // Decode
  // ---------------------------------------------------------
  logic [20:0] mode_code;
  logic [7:0] frame_node;
  logic frame_ok;
  logic mode_ok;
  logic len_ok;
  logic addressed;
  logic [3:0] need_len;
  logic [63:0] pl;

  assign pl = cap_frame.data;
  assign mode_code = cap_frame.ident[`MODE_MSB:`MODE_LSB];
  assign frame_node = cap_frame.ident[`NODE_MSB:`NODE_LSB];
  assign frame_ok = cap_frame.extended && !cap_frame.remote;
  assign addressed = frame_node == node_id;
  assign mode_ok = mode_code <= `MODE_MAX;

  assign need_len = need_dlc(mode_code);

  assign len_ok = cap_frame.dlc >= need_len;

  // ---------------------------------------------------------
  // Acceptance
  // ---------------------------------------------------------
  logic accept;
  logic origin_cmd;
  logic origin_bad;
  logic [7:0] origin_byte;
  logic [31:0] word0;
  logic [15:0] spd_half;
  logic [15:0] acc_half;

  assign accept = cap_valid && frame_ok && addressed && mode_ok
                  && len_ok;
  assign origin_cmd = mode_code == `MODE_SET_ORIGIN;
  assign origin_byte = pl[63:56];
  assign origin_bad = origin_cmd && origin_byte > `ORIGIN_MAX;
  assign word0 = be_word(pl, 0);
  assign spd_half = be_half(pl, 4);
  assign acc_half = be_half(pl, 6);

  // ---------------------------------------------------------
  // Running mode
  // ---------------------------------------------------------
  servo_cmd_pkg::servo_mode_t mode_d, mode_q;
  logic spv_d, spv_q;

  always_comb begin
    mode_d = mode_q;
    spv_d = spv_q;
    if (accept && !origin_cmd) begin
      mode_d = to_mode(mode_code[2:0]);
      spv_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= servo_cmd_pkg::cmd_duty_cycle;
      spv_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      spv_q <= spv_d;
    end
  end

  // ---------------------------------------------------------
  // Single-word setpoints
  // ---------------------------------------------------------
  logic signed [31:0] duty_d, duty_q;
  logic signed [31:0] qcur_d, qcur_q;
  logic signed [31:0] brake_d, brake_q;
  logic signed [31:0] speed_d, speed_q;
  logic signed [31:0] pos_d, pos_q;

  always_comb begin
    duty_d = duty_q;
    qcur_d = qcur_q;
    brake_d = brake_q;
    speed_d = speed_q;
    pos_d = pos_q;
    if (accept) begin
      unique case (mode_code[2:0])
        3'h0: begin
          duty_d = word0;
        end
        3'h1: begin
          qcur_d = word0;
        end
        3'h2: begin
          brake_d = word0;
        end
        3'h3: begin
          speed_d = word0;
        end
        3'h4: begin
          pos_d = word0;
        end
        default: begin
          pos_d = pos_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      duty_q <= '0;
      qcur_q <= '0;
      brake_q <= '0;
      speed_q <= '0;
      pos_q <= '0;
    end else begin
      duty_q <= duty_d;
      qcur_q <= qcur_d;
      brake_q <= brake_d;
      speed_q <= speed_d;
      pos_q <= pos_d;
    end
  end

  // ---------------------------------------------------------
  // Position-speed setpoints
  // ---------------------------------------------------------
  logic signed [31:0] ps_pos_d, ps_pos_q;
  logic signed [15:0] ps_spd_d, ps_spd_q;
  logic [15:0] ps_acc_d, ps_acc_q;

  always_comb begin
    ps_pos_d = ps_pos_q;
    ps_spd_d = ps_spd_q;
    ps_acc_d = ps_acc_q;
    if (accept && mode_code == `MODE_POSITION_SPEED) begin
      ps_pos_d = word0;
      ps_spd_d = spd_half;
      ps_acc_d = acc_half & `ACCEL_MAX;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ps_pos_q <= '0;
      ps_spd_q <= '0;
      ps_acc_q <= '0;
    end else begin
      ps_pos_q <= ps_pos_d;
      ps_spd_q <= ps_spd_d;
      ps_acc_q <= ps_acc_d;
    end
  end

  // ---------------------------------------------------------
  // Command pulses
  // ---------------------------------------------------------
  logic strobe_d, strobe_q;
  logic drop_d, drop_q;

  always_comb begin
    strobe_d = 1'b0;
    drop_d = 1'b0;
    if (accept) begin
      strobe_d = !origin_bad;
    end
    if (cap_valid && frame_ok && addressed && !accept) begin
      drop_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strobe_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      strobe_q <= strobe_d;
      drop_q <= drop_d;
    end
  end

  // ---------------------------------------------------------
  // Origin pulses
  // ---------------------------------------------------------
  logic otmp_d, otmp_q;
  logic operm_d, operm_q;
  logic ooth_d, ooth_q;

  always_comb begin
    otmp_d = 1'b0;
    operm_d = 1'b0;
    ooth_d = 1'b0;
    if (accept && origin_cmd) begin
      otmp_d = origin_is(origin_byte, 8'h00);
      operm_d = origin_is(origin_byte, 8'h01);
      ooth_d = origin_is(origin_byte, `ORIGIN_MAX);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      otmp_q <= 1'b0;
      operm_q <= 1'b0;
      ooth_q <= 1'b0;
    end else begin
      otmp_q <= otmp_d;
      operm_q <= operm_d;
      ooth_q <= ooth_d;
    end
  end

  // ---------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------
  assign setpoint = {mode_q, duty_q, qcur_q, brake_q, speed_q, pos_q,
                     ps_pos_q, ps_spd_q, ps_acc_q};
  assign setpoint_valid = spv_q;
  assign cmd_strobe = strobe_q;
  assign origin_temporary = otmp_q;
  assign origin_permanent = operm_q;
  assign origin_other = ooth_q;
  assign frame_dropped = drop_q;

endmodule

`default_nettype wire

// ==== logic/servo_cmd_pkg.sv ====
`default_nettype none
package servo_cmd_pkg;

  typedef enum logic [2:0] {
    cmd_duty_cycle,
    cmd_current_loop,
    cmd_brake_current,
    cmd_speed_loop,
    cmd_position_loop,
    cmd_set_origin,
    cmd_position_speed_loop
  } servo_mode_t;

  // Received CAN frame as handed over by the controller
  typedef struct packed {
    logic extended;
    logic remote;
    logic [28:0] ident;
    logic [3:0] dlc;
    logic [63:0] data;
  } can_frame_t;

  // Decoded setpoints
  typedef struct packed {
    servo_mode_t mode;
    logic signed [31:0] duty_cycle;
    logic signed [31:0] quadrature_current;
    logic signed [31:0] brake_current;
    logic signed [31:0] speed;
    logic signed [31:0] position;
    logic signed [31:0] ps_position;
    logic signed [15:0] ps_speed;
    logic [15:0] ps_accel;
  } servo_setpoint_t;

endpackage
`default_nettype wire

// ==== logic/servo_cmd_regs.svh ====
`ifndef SERVO_CMD_REGS_SVH
`define SERVO_CMD_REGS_SVH

`define MODE_DUTY_CYCLE 21'h000000
`define MODE_CURRENT_LOOP 21'h000001
`define MODE_BRAKE_CURRENT 21'h000002
`define MODE_SPEED_LOOP 21'h000003
`define MODE_POSITION_LOOP 21'h000004
`define MODE_SET_ORIGIN 21'h000005
`define MODE_POSITION_SPEED 21'h000006
`define MODE_MAX 21'h000006
`define MODE_LSB 8
`define MODE_MSB 28
`define NODE_MSB 7
`define NODE_LSB 0
`define LEN_WORD 4'h4
`define LEN_ORIGIN 4'h1
`define LEN_POS_SPD 4'h8
`define ORIGIN_MAX 8'h02
`define ACCEL_MAX 16'h7FFF

`endif

// ==== verification/can_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module can_host_model (
  // Clock
  input wire logic clk,
  // Frame out
  output logic rx_valid,
  output servo_cmd_pkg::can_frame_t rx_frame
);
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  // Sends one frame; a nonzero gap releases the lines
  task automatic send(input logic [20:0] md, input logic [7:0] nd,
      input logic [3:0] dl, input logic [63:0] d, input logic ext,
      input int gap);
    rx_valid = 1'b1;
    rx_frame = {ext, 1'b0, md, nd, dl, d};
    @(posedge clk);
    #2;
    if (gap > 0) begin
      rx_valid = 1'b0;
      rx_frame = ~rx_frame;
    end
  endtask
endmodule
`default_nettype wire

// ==== verification/servo_cmd_checker_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module servo_cmd_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs
  input wire logic [7:0] node_id,
  input wire logic rx_valid,
  input wire servo_cmd_pkg::can_frame_t rx_frame,
  // Outputs
  input wire servo_cmd_pkg::servo_setpoint_t setpoint,
  input wire logic setpoint_valid,
  input wire logic cmd_strobe,
  input wire logic origin_temporary,
  input wire logic origin_permanent,
  input wire logic origin_other,
  input wire logic frame_dropped
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [20:0] md;
  logic [7:0] b0;
  logic mine, fit, gx;
  assign md = rx_frame.ident[28:8];
  assign b0 = rx_frame.data[63:56];
  assign mine = rx_valid && rx_frame.extended && !rx_frame.remote
    && rx_frame.ident[7:0] == node_id;
  assign fit = md <= 21'h6 && rx_frame.dlc >= (md == 21'h5 ? 4'h1 :
    md == 21'h6 ? 4'h8 : 4'h4);
  assign gx = mine && fit && !(md == 21'h5 && b0 > 8'h02);
  a_strobe_on_accept: assert property (gx |-> ##2 cmd_strobe)
    else $error("strobe missing");
  a_strobe_has_cause: assert property (cmd_strobe |-> $past(gx, 2))
    else $error("strobe without frame");
  a_drop_bad: assert property (mine && !fit |-> ##2 frame_dropped)
    else $error("drop missing");
  a_other_quiet: assert property (rx_valid && !mine |-> ##2
    !cmd_strobe && !frame_dropped) else $error("foreign frame used");
  a_current_value: assert property (gx && md == 21'h1 |-> ##2
    setpoint.quadrature_current == $past(rx_frame.data[63:32], 2))
    else $error("current wrong");
  a_posspd_fields: assert property (gx && md == 21'h6 |-> ##2
    setpoint.ps_position == $past(rx_frame.data[63:32], 2)
    && setpoint.ps_speed == $past(rx_frame.data[31:16], 2))
    else $error("pos-speed wrong");
  a_mode_field: assert property (gx && md != 21'h5 |-> ##2
    setpoint.mode == $past(rx_frame.ident[10:8], 2))
    else $error("mode wrong");
  a_origin_kind: assert property (gx && md == 21'h5 |-> ##2
    origin_temporary == ($past(b0, 2) == 8'h00)
    && origin_permanent == ($past(b0, 2) == 8'h01))
    else $error("origin wrong");
  a_hold_fields: assert property ($changed(setpoint) |-> cmd_strobe)
    else $error("setpoint moved");
  c_current: cover property (gx && md == 21'h1);
  c_drop: cover property (frame_dropped);
  c_origin: cover property (origin_permanent);
endmodule
bind servo_can_command_decoder servo_cmd_checker i_chk (.clk, .sys_rst,
  .node_id, .rx_valid, .rx_frame, .setpoint, .setpoint_valid, .cmd_strobe,
  .origin_temporary, .origin_permanent, .origin_other, .frame_dropped);
`default_nettype wire

// ==== verification/test_servo_can_command_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_servo_can_command_decoder;
  logic clk, sys_rst, rx_valid, setpoint_valid, cmd_strobe, frame_dropped;
  logic origin_temporary, origin_permanent, origin_other;
  logic [7:0] node_id;
  logic [4:0] pulses;
  servo_cmd_pkg::can_frame_t rx_frame;
  servo_cmd_pkg::servo_setpoint_t setpoint;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  assign pulses = {cmd_strobe, frame_dropped, origin_temporary,
    origin_permanent, origin_other};
  servo_can_command_decoder i_dut (.clk, .sys_rst, .node_id, .rx_valid,
    .rx_frame, .setpoint, .setpoint_valid, .cmd_strobe, .origin_temporary,
    .origin_permanent, .origin_other, .frame_dropped);
  can_host_model i_host (.clk, .rx_valid, .rx_frame);
  // ------------------------------------
  // Helpers and scenarios
  // ------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic idle;
    @(posedge clk);
    #2;
  endtask
  task automatic try(input logic [20:0] md, input logic [7:0] nd,
      input logic [3:0] dl, input logic ext, input logic [7:0] b0,
      input logic [4:0] exp);
    i_host.send(md, nd, dl, {b0, 56'h0}, ext, 1);
    idle;
    chk(pulses, exp);
  endtask
  task automatic t_modes;
    logic [31:0] v[5] = '{32'h000186A0, 32'hFFFF15A0, 32'h0000EA60,
      32'hFFFE7960, 32'h15752A00};
    logic [31:0] f;
    for (int m = 0; m < 5; m++) begin
      i_host.send(21'(m), node_id, 4'h4, {v[m], 32'h0}, 1'b1, 1);
      idle;
      case (m)
        0: f = setpoint.duty_cycle;
        1: f = setpoint.quadrature_current;
        2: f = setpoint.brake_current;
        3: f = setpoint.speed;
        default: f = setpoint.position;
      endcase
      chk(pulses, 5'h10);
      chk(setpoint.mode, m);
      chk(f, v[m]);
      idle;
    end
  endtask
  task automatic t_pair;
    i_host.send(21'h1, node_id, 4'h4, 64'h0000EA60_00000000, 1'b1, 0);
    i_host.send(21'h6, node_id, 4'h8, 64'hFDDAAF00_8000_7FFF, 1'b1, 1);
    idle;
    chk({setpoint.ps_position, setpoint.ps_speed, setpoint.ps_accel},
      64'hFDDAAF00_8000_7FFF);
    chk({setpoint.quadrature_current}, 32'h0000EA60);
    idle;
  endtask
  task automatic t_reject;
    servo_cmd_pkg::servo_setpoint_t s;
    s = setpoint;
    try(21'h5, node_id, 4'h1, 1'b1, 8'h01, 5'h12);
    try(21'h5, node_id, 4'h1, 1'b1, 8'h00, 5'h14);
    try(21'h5, node_id, 4'h1, 1'b1, 8'h02, 5'h11);
    try(21'h5, node_id, 4'h1, 1'b1, 8'h03, 5'h00);
    try(21'h1, node_id ^ 8'h01, 4'h4, 1'b1, 8'h01, 5'h00);
    try(21'h1, node_id, 4'h4, 1'b0, 8'h01, 5'h00);
    try(21'h7, node_id, 4'h8, 1'b1, 8'h01, 5'h08);
    try(21'h100006, node_id, 4'h8, 1'b1, 8'h01, 5'h08);
    try(21'h6, node_id, 4'h7, 1'b1, 8'h01, 5'h08);
    try(21'h5, node_id, 4'h0, 1'b1, 8'h01, 5'h08);
    chk(setpoint === s, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    sys_rst = 1'b1;
    node_id = 8'h2A;
    repeat (20) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    idle;
    chk({pulses, setpoint_valid}, 6'h00);
    t_modes;
    chk(setpoint_valid, 1'b1);
    t_pair;
    t_reject;
    wrap_up;
  end
endmodule
`default_nettype wire
